// file: verilog/rcp_pkg.sv
// Constants, address fields and helper functions for the region configuration registers.
package rcp_pkg;

	// ------------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------------
	localparam int          RCP_NUM_REGIONS = 32;
	localparam int          RCP_SLICE_W     = 16;
	localparam int          RCP_MEM_DEPTH   = 124;
	localparam int          RCP_MEM_W       = 24;
	localparam logic [6:0]  RCP_MEM_WORDS   = 7'h7C;

	// ------------------------------------------------------------------
	// Control address fields
	// ------------------------------------------------------------------
	localparam int          RCP_REGION_HI   = 15;
	localparam int          RCP_REGION_LO   = 11;
	localparam int          RCP_GROUP_HI    = 10;
	localparam int          RCP_GROUP_LO    = 8;
	localparam int          RCP_BCAST_BIT   = 7;
	localparam int          RCP_OFFSET_HI   = 6;
	localparam int          RCP_TOGGLE_BIT  = 4;
	localparam int          RCP_SEL_HI      = 3;

	// Register or memory group codes.
	localparam logic [2:0]  RCP_GRP_LOW     = 3'h1;
	localparam logic [2:0]  RCP_GRP_HIGH    = 3'h2;
	localparam logic [2:0]  RCP_GRP_REGS    = 3'h3;
	localparam logic [2:0]  RCP_GRP_PIX     = 3'h4;

	// Region register offsets.
	localparam logic [6:0]  RCP_OFF_DCOL    = 7'h00;
	localparam logic [6:0]  RCP_OFF_STATUS  = 7'h01;

	// Pixel control select bits.
	localparam int          RCP_SEL_COL1    = 0;
	localparam int          RCP_SEL_COL2    = 1;
	localparam int          RCP_SEL_ROW     = 2;
	localparam int          RCP_SEL_PULSE   = 3;
	localparam logic [3:0]  RCP_ONE_COL1    = 4'h1;
	localparam logic [3:0]  RCP_ONE_COL2    = 4'h2;
	localparam logic [3:0]  RCP_ONE_ROW     = 4'h4;
	localparam logic [3:0]  RCP_ONE_PULSE   = 4'h8;

	// Global pixel configuration register.
	localparam logic [15:0] RCP_PIXCFG_ADDR = 16'h0500;
	localparam int          RCP_PIXCFG_SEL  = 0;
	localparam int          RCP_PIXCFG_DATA = 1;

	// Status bit positions.
	localparam int          RCP_STAT_PIXEL  = 0;
	localparam int          RCP_STAT_MEMORY = 1;
	localparam int          RCP_STAT_ALLDIS = 2;

	// Reset values.
	localparam logic [15:0] RCP_SLICE_RST   = 16'hFFFF;
	localparam logic [15:0] RCP_DCOL_RST    = 16'h0000;
	localparam logic [15:0] RCP_HOLD_RST    = 16'h0000;
	localparam logic        RCP_FLAG_RST    = 1'h0;

	// ------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------
	// True when an address reaches region r directly or by broadcast.
	function automatic logic rcp_region_hit(input logic [15:0] addr, input logic [4:0] r);
		rcp_region_hit = addr[RCP_BCAST_BIT] || (addr[RCP_REGION_HI:RCP_REGION_LO] == r);
	endfunction

	// New value of a row or column slice on a pixel control write.
	function automatic logic [15:0] rcp_slice_write(input logic [15:0] cur, input logic [15:0] data,
		input logic toggle);
		rcp_slice_write = toggle ? ~cur : data;
	endfunction

endpackage

// file: verilog/rcp_ram_if.sv
// Carrier between the register bank and one region FIFO memory.
`timescale 1ns/1ps
interface rcp_ram_if;
	import rcp_pkg::*;

	logic                 we;
	logic [6:0]           addr;
	logic [RCP_MEM_W-1:0] wdata;
	logic [RCP_MEM_W-1:0] rdata;

	modport host (output we, output addr, output wdata, input rdata);
	modport mem  (input we, input addr, input wdata, output rdata);
endinterface

// file: verilog/rcp_region_ram.sv
// One region FIFO memory with a registered read port.
`timescale 1ns/1ps
module rcp_region_ram
	import rcp_pkg::*;
(
	input  wire logic clk_in,
	rcp_ram_if.mem    ram
);

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	logic [RCP_MEM_W-1:0] mem_array [RCP_MEM_DEPTH];
	logic [RCP_MEM_W-1:0] rdata_reg;
	logic                 in_range;

	// Locations past the last word are neither written nor read.
	assign in_range  = (ram.addr < RCP_MEM_WORDS);
	assign ram.rdata = rdata_reg;

	// Write the addressed word and register the addressed read.
	always_ff @(posedge clk_in)
	begin
		if (ram.we && in_range)
		begin
			mem_array[ram.addr] <= ram.wdata;
		end
		rdata_reg <= in_range ? mem_array[ram.addr] : '0;
	end

endmodule

// file: verilog/rcp_region_config.sv
// Region register bank, FIFO memory access and pixel selection line drivers.
`timescale 1ns/1ps
// Overview of operation
// - Memory access only in configuration mode
// - Low half write only fills holding register
// - Low half read returns word bits 15:0
// - High half write stores full 24-bit word
// - High half read returns word bits 23:16
// - Disable bits exclude double columns from readout
// - Readout sets pixel flag on stuck pixel
// - Readout disables encoder holding stuck pixel
// - Pixel flag stays until software writes zero
// - Self-test sets memory flag, zero clears
// - Read-only flag when all columns disabled
// - Pixel control address field decoding
// - One select bit per slice, several allowed
// - Toggle inverts row/column, pulse never toggles
// - Pixel broadcast writes every region
// - Two column slices drive 32 columns
// - Sixteen rows per region, region 0 top
// - Target select routes rows, other held zero
// - Pixels latch buffered value on row and column
// - Pulse slice gates global pulse per region
// - Region group codes and word offset decoding
// - Each region holds 124 words of 24 bits
// - Region broadcast writes every region
module rcp_region_config
	import rcp_pkg::*;
(
	input  wire logic         clk_in,
	input  wire logic         resetn_in,
	input  wire logic         config_mode_in,
	input  wire logic         ctrl_wr_in,
	input  wire logic         ctrl_rd_in,
	input  wire logic [15:0]  ctrl_addr_in,
	input  wire logic [15:0]  ctrl_wdata_in,
	output logic      [15:0]  ctrl_rdata_out,
	output logic              ctrl_rvalid_out,
	input  wire logic         fault_pixel_in,
	input  wire logic [4:0]   fault_region_in,
	input  wire logic [3:0]   fault_dcol_in,
	input  wire logic         mem_fail_in,
	input  wire logic [4:0]   mem_fail_region_in,
	input  wire logic         global_pulse_in,
	output logic      [511:0] dcol_disable_out,
	output logic      [1023:0] col_sel_out,
	output logic      [511:0] mask_row_out,
	output logic      [511:0] pulse_row_out,
	output logic      [511:0] pulse_col_out,
	output logic              pixel_cfg_value_out
);

	// ------------------------------------------------------------------
	// Reset synchroniser
	// ------------------------------------------------------------------
	logic rst_meta_reg;
	logic rst_n;

	// Release of the asynchronous reset passes two flip-flops.
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	logic [15:0]          dcol_reg   [RCP_NUM_REGIONS];
	logic [15:0]          dcol_next  [RCP_NUM_REGIONS];
	logic [15:0]          col1_reg   [RCP_NUM_REGIONS];
	logic [15:0]          col1_next  [RCP_NUM_REGIONS];
	logic [15:0]          col2_reg   [RCP_NUM_REGIONS];
	logic [15:0]          col2_next  [RCP_NUM_REGIONS];
	logic [15:0]          row_reg    [RCP_NUM_REGIONS];
	logic [15:0]          row_next   [RCP_NUM_REGIONS];
	logic [15:0]          pulse_reg  [RCP_NUM_REGIONS];
	logic [15:0]          pulse_next [RCP_NUM_REGIONS];
	logic [31:0]          pixflag_reg;
	logic [31:0]          pixflag_next;
	logic [31:0]          memflag_reg;
	logic [31:0]          memflag_next;
	logic [31:0]          all_dis;
	logic [31:0]          mem_we;
	logic [RCP_MEM_W-1:0] mem_rd     [RCP_NUM_REGIONS];
	logic [15:0]          hold_reg;
	logic                 regsel_reg;
	logic                 pixdata_reg;
	logic                 pixbuf_reg;
	logic [15:0]          rd_addr_reg;
	logic                 rd_cfg_reg;
	logic                 rd_pend_reg;
	logic [15:0]          rdata_reg;
	logic                 rvalid_reg;

	// ------------------------------------------------------------------
	// Address decoding
	// ------------------------------------------------------------------
	logic [2:0]  wr_grp;
	logic [6:0]  wr_off;
	logic [3:0]  wr_sel;
	logic        wr_toggle;
	logic        wr_low;
	logic        wr_high;
	logic        wr_regs;
	logic        wr_pix;
	logic        wr_pixcfg;
	logic        mem_ok;
	logic [6:0]  ram_addr;

	// Field split of the incoming control address.
	assign wr_grp    = ctrl_addr_in[RCP_GROUP_HI:RCP_GROUP_LO];
	assign wr_off    = ctrl_addr_in[RCP_OFFSET_HI:0];
	assign wr_sel    = ctrl_addr_in[RCP_SEL_HI:0];
	assign wr_toggle = ctrl_addr_in[RCP_TOGGLE_BIT];
	assign mem_ok    = config_mode_in && (wr_off < RCP_MEM_WORDS);
	assign wr_low    = ctrl_wr_in && (wr_grp == RCP_GRP_LOW) && config_mode_in;
	assign wr_high   = ctrl_wr_in && (wr_grp == RCP_GRP_HIGH) && mem_ok;
	assign wr_regs   = ctrl_wr_in && (wr_grp == RCP_GRP_REGS);
	assign wr_pix    = ctrl_wr_in && (wr_grp == RCP_GRP_PIX);
	assign wr_pixcfg = ctrl_wr_in && (ctrl_addr_in == RCP_PIXCFG_ADDR);
	assign ram_addr  = wr_off;

	// ------------------------------------------------------------------
	// Region memories
	// ------------------------------------------------------------------
	rcp_ram_if ram_bus [RCP_NUM_REGIONS] ();

	// One memory per region; only the high half write stores a word.
	for (genvar g = 0; g < RCP_NUM_REGIONS; g++)
	begin : g_region
		assign mem_we[g]         = wr_high && rcp_region_hit(ctrl_addr_in, 5'(g));
		assign ram_bus[g].we     = mem_we[g];
		assign ram_bus[g].addr   = ram_addr;
		assign ram_bus[g].wdata  = {ctrl_wdata_in[7:0], hold_reg};
		assign mem_rd[g]         = ram_bus[g].rdata;
		assign all_dis[g]        = &dcol_reg[g];
		assign dcol_disable_out[g*16 +: 16] = dcol_reg[g];
		assign col_sel_out[g*32 +: 32]      = {col2_reg[g], col1_reg[g]};
		assign mask_row_out[g*16 +: 16]     = regsel_reg ? 16'h0000 : row_reg[g];
		assign pulse_row_out[g*16 +: 16]    = regsel_reg ? row_reg[g] : 16'h0000;
		assign pulse_col_out[g*16 +: 16]    = pulse_reg[g] & {16{global_pulse_in}};

		rcp_region_ram u_ram
		(
			.clk_in (clk_in),
			.ram    (ram_bus[g].mem)
		);
	end

	// ------------------------------------------------------------------
	// Next state of the per-region registers
	// ------------------------------------------------------------------
	// Software writes come first; hardware events are applied last so that they win.
	always_comb
	begin
		for (int r = 0; r < RCP_NUM_REGIONS; r++)
		begin
			dcol_next[r]    = dcol_reg[r];
			col1_next[r]    = col1_reg[r];
			col2_next[r]    = col2_reg[r];
			row_next[r]     = row_reg[r];
			pulse_next[r]   = pulse_reg[r];
			pixflag_next[r] = pixflag_reg[r];
			memflag_next[r] = memflag_reg[r];
			if (rcp_region_hit(ctrl_addr_in, 5'(r)))
			begin
				if (wr_regs && (wr_off == RCP_OFF_DCOL))
				begin
					dcol_next[r] = ctrl_wdata_in;
				end
				if (wr_regs && (wr_off == RCP_OFF_STATUS))
				begin
					pixflag_next[r] = pixflag_reg[r] & ctrl_wdata_in[RCP_STAT_PIXEL];
					memflag_next[r] = memflag_reg[r] & ctrl_wdata_in[RCP_STAT_MEMORY];
				end
				if (wr_pix && wr_sel[RCP_SEL_COL1])
				begin
					col1_next[r] = rcp_slice_write(col1_reg[r], ctrl_wdata_in, wr_toggle);
				end
				if (wr_pix && wr_sel[RCP_SEL_COL2])
				begin
					col2_next[r] = rcp_slice_write(col2_reg[r], ctrl_wdata_in, wr_toggle);
				end
				if (wr_pix && wr_sel[RCP_SEL_ROW])
				begin
					row_next[r] = rcp_slice_write(row_reg[r], ctrl_wdata_in, wr_toggle);
				end
				if (wr_pix && wr_sel[RCP_SEL_PULSE] && !wr_toggle)
				begin
					pulse_next[r] = ctrl_wdata_in;
				end
			end
			if (fault_pixel_in && (fault_region_in == 5'(r)))
			begin
				pixflag_next[r]             = 1'b1;
				dcol_next[r][fault_dcol_in] = 1'b1;
			end
			if (mem_fail_in && (mem_fail_region_in == 5'(r)))
			begin
				memflag_next[r] = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Register update
	// ------------------------------------------------------------------
	// Per-region registers.
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dcol_reg    <= '{default: RCP_DCOL_RST};
			col1_reg    <= '{default: RCP_SLICE_RST};
			col2_reg    <= '{default: RCP_SLICE_RST};
			row_reg     <= '{default: RCP_SLICE_RST};
			pulse_reg   <= '{default: RCP_SLICE_RST};
			pixflag_reg <= '0;
			memflag_reg <= '0;
		end
		else
		begin
			dcol_reg    <= dcol_next;
			col1_reg    <= col1_next;
			col2_reg    <= col2_next;
			row_reg     <= row_next;
			pulse_reg   <= pulse_next;
			pixflag_reg <= pixflag_next;
			memflag_reg <= memflag_next;
		end
	end

	// Low half holding register; the memory itself is untouched here.
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hold_reg <= RCP_HOLD_RST;
		end
		else if (wr_low)
		begin
			hold_reg <= ctrl_wdata_in;
		end
	end

	// Global pixel configuration and the buffered value sent to all pixels.
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			regsel_reg  <= RCP_FLAG_RST;
			pixdata_reg <= RCP_FLAG_RST;
			pixbuf_reg  <= RCP_FLAG_RST;
		end
		else
		begin
			if (wr_pixcfg)
			begin
				regsel_reg  <= ctrl_wdata_in[RCP_PIXCFG_SEL];
				pixdata_reg <= ctrl_wdata_in[RCP_PIXCFG_DATA];
			end
			pixbuf_reg <= pixdata_reg;
		end
	end

	assign pixel_cfg_value_out = pixbuf_reg;

	// ------------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------------
	logic [4:0]  rd_rg;
	logic [2:0]  rd_grp;
	logic [6:0]  rd_off;
	logic [3:0]  rd_sel;
	logic        rd_mem;
	logic [15:0] rd_word;

	// Fields of the read captured one cycle earlier, while the memory answers.
	assign rd_rg  = rd_addr_reg[RCP_REGION_HI:RCP_REGION_LO];
	assign rd_grp = rd_addr_reg[RCP_GROUP_HI:RCP_GROUP_LO];
	assign rd_off = rd_addr_reg[RCP_OFFSET_HI:0];
	assign rd_sel = rd_addr_reg[RCP_SEL_HI:0];
	assign rd_mem = rd_cfg_reg && (rd_off < RCP_MEM_WORDS);

	// Read data selection; a select field without exactly one bit reads zero.
	assign rd_word =
		(rd_grp == RCP_GRP_LOW  && rd_mem) ? mem_rd[rd_rg][15:0] :
		(rd_grp == RCP_GRP_HIGH && rd_mem) ? {8'h00, mem_rd[rd_rg][23:16]} :
		(rd_grp == RCP_GRP_REGS && rd_off == RCP_OFF_DCOL) ? dcol_reg[rd_rg] :
		(rd_grp == RCP_GRP_REGS && rd_off == RCP_OFF_STATUS) ?
			{13'h0000, all_dis[rd_rg], memflag_reg[rd_rg], pixflag_reg[rd_rg]} :
		(rd_grp == RCP_GRP_PIX && rd_sel == RCP_ONE_COL1)  ? col1_reg[rd_rg] :
		(rd_grp == RCP_GRP_PIX && rd_sel == RCP_ONE_COL2)  ? col2_reg[rd_rg] :
		(rd_grp == RCP_GRP_PIX && rd_sel == RCP_ONE_ROW)   ? row_reg[rd_rg] :
		(rd_grp == RCP_GRP_PIX && rd_sel == RCP_ONE_PULSE) ? pulse_reg[rd_rg] :
		(rd_addr_reg == RCP_PIXCFG_ADDR) ? {14'h0000, pixdata_reg, regsel_reg} :
		16'h0000;

	// Two-stage read pipeline: capture the request, then register the answer.
	always_ff @(posedge clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rd_addr_reg <= 16'h0000;
			rd_cfg_reg  <= 1'b0;
			rd_pend_reg <= 1'b0;
			rdata_reg   <= 16'h0000;
			rvalid_reg  <= 1'b0;
		end
		else
		begin
			rd_pend_reg <= ctrl_rd_in;
			if (ctrl_rd_in)
			begin
				rd_addr_reg <= ctrl_addr_in;
				rd_cfg_reg  <= config_mode_in;
			end
			rvalid_reg <= rd_pend_reg;
			if (rd_pend_reg)
			begin
				rdata_reg <= rd_word;
			end
		end
	end

	assign ctrl_rdata_out  = rdata_reg;
	assign ctrl_rvalid_out = rvalid_reg;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n);

	a_mem_cfg_only: assert property (!config_mode_in |-> mem_we == 32'h0000_0000)
		else $error("Memory written outside configuration mode.");
	a_low_holds_only: assert property (wr_low |-> (mem_we == 32'h0000_0000) ##1 (hold_reg == $past(ctrl_wdata_in)))
		else $error("Low half write did not only fill the holding register.");
	a_read_latency: assert property (ctrl_rd_in && !$past(ctrl_rd_in, 2) |-> !ctrl_rvalid_out ##2 ctrl_rvalid_out)
		else $error("Read answer not exactly two cycles after request.");
	a_fault_flag_set: assert property (fault_pixel_in |=> pixflag_reg[$past(fault_region_in)])
		else $error("Pixel flag not set by faulty pixel.");
	a_fault_dcol_set: assert property (fault_pixel_in |=> dcol_reg[$past(fault_region_in)][$past(fault_dcol_in)])
		else $error("Faulty pixel did not disable its encoder.");
	a_flag_sticky: assert property (pixflag_reg[0] && !(wr_regs && rcp_region_hit(ctrl_addr_in, 5'h00)) |=> pixflag_reg[0])
		else $error("Pixel flag cleared without a status write.");
	a_toggle_col: assert property (wr_pix && wr_toggle && wr_sel[RCP_SEL_COL1] && rcp_region_hit(ctrl_addr_in, 5'h01)
		|=> col1_reg[1] == ~$past(col1_reg[1]))
		else $error("Column slice did not invert on toggle write.");
	a_pulse_no_toggle: assert property (wr_pix && wr_toggle |=> $stable(pulse_reg[1]))
		else $error("Pulse slice changed on toggle write.");
	a_unsel_rows_zero: assert property (regsel_reg |-> mask_row_out == 512'h0)
		else $error("Mask rows driven while pulse rows selected.");
	a_bcast_all: assert property (wr_pix && ctrl_addr_in[RCP_BCAST_BIT] && !wr_toggle && wr_sel[RCP_SEL_ROW]
		|=> row_reg[31] == $past(ctrl_wdata_in) && row_reg[0] == $past(ctrl_wdata_in))
		else $error("Broadcast write missed a region.");

endmodule

// file: verif/rcp_ctrl_model.sv
// Behavioural model of the control transaction decoder that drives the register bank.
`timescale 1ns/1ps
module rcp_ctrl_model
	import rcp_pkg::*;
(
	input  wire logic        clk_in,
	output logic             wr_out,
	output logic             rd_out,
	output logic [15:0]      addr_out,
	output logic [15:0]      wdata_out,
	input  wire logic [15:0] rdata_in,
	input  wire logic        rvalid_in
);
	// ------------------------------------------------------------------
	// Transaction tasks
	// ------------------------------------------------------------------
	// Strobes idle low from time zero.
	initial
	begin
		wr_out = 1'b0;
		rd_out = 1'b0;
		addr_out = 16'h0000;
		wdata_out = 16'h0000;
	end

	// One write strobe; released lines show the inverse so stale values never look valid.
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk_in);
		wr_out = 1'b1;
		addr_out = a;
		wdata_out = d;
		@(negedge clk_in);
		wr_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~d;
	endtask

	// A 24-bit word always goes as the low half first, then the high half.
	task automatic wr_word(input logic [15:0] a, input logic [23:0] w);
		wr(a, w[15:0]);
		wr({a[15:11], RCP_GRP_HIGH, a[7:0]}, {8'h00, w[23:16]});
	endtask

	// One read; callers name a single slice on pixel control readback.
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		int n;
		@(negedge clk_in);
		rd_out = 1'b1;
		addr_out = a;
		@(negedge clk_in);
		rd_out = 1'b0;
		addr_out = ~a;
		n = 0;
		while (rvalid_in !== 1'b1 && n < 4)
		begin
			@(negedge clk_in);
			n++;
		end
		d = (rvalid_in === 1'b1) ? rdata_in : 16'hXXXX;
	endtask
endmodule

// file: verif/region_config_and_pixel_select_regs_test.sv
// Self-checking testbench for the region register bank and pixel selection drivers.
`timescale 1ns/1ps
`define chk_eq(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
	$display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module region_config_and_pixel_select_regs_test;
	import rcp_pkg::*;
	logic          clk_in             = 1'b0;
	logic          resetn_in          = 1'b0;
	logic          config_mode_in     = 1'b0;
	logic          fault_pixel_in     = 1'b0;
	logic [4:0]    fault_region_in    = 5'h00;
	logic [3:0]    fault_dcol_in      = 4'h0;
	logic          mem_fail_in        = 1'b0;
	logic [4:0]    mem_fail_region_in = 5'h00;
	logic          global_pulse_in    = 1'b0;
	logic          wr;
	logic          rd;
	logic [15:0]   addr;
	logic [15:0]   wdata;
	logic [15:0]   rdata;
	logic          rvalid;
	logic [511:0]  dcol;
	logic [1023:0] col_sel;
	logic [511:0]  mask_row;
	logic [511:0]  pulse_row;
	logic [511:0]  pulse_col;
	logic          pcv;
	int            err_total          = 0;
	int            total_checks       = 0;

	// ------------------------------------------------------------------
	// Clock, instances and helpers
	// ------------------------------------------------------------------
	// The 40 MHz system clock.
	always #12.5 clk_in = ~clk_in;

	rcp_region_config i_rcp_region_config (.clk_in(clk_in), .resetn_in(resetn_in),
		.config_mode_in(config_mode_in), .ctrl_wr_in(wr), .ctrl_rd_in(rd), .ctrl_addr_in(addr),
		.ctrl_wdata_in(wdata), .ctrl_rdata_out(rdata), .ctrl_rvalid_out(rvalid),
		.fault_pixel_in(fault_pixel_in), .fault_region_in(fault_region_in), .fault_dcol_in(fault_dcol_in),
		.mem_fail_in(mem_fail_in), .mem_fail_region_in(mem_fail_region_in),
		.global_pulse_in(global_pulse_in), .dcol_disable_out(dcol), .col_sel_out(col_sel),
		.mask_row_out(mask_row), .pulse_row_out(pulse_row), .pulse_col_out(pulse_col),
		.pixel_cfg_value_out(pcv));

	rcp_ctrl_model i_rcp_ctrl_model (.clk_in(clk_in), .wr_out(wr), .rd_out(rd), .addr_out(addr),
		.wdata_out(wdata), .rdata_in(rdata), .rvalid_in(rvalid));

	// Address from region, group and low byte (bit 7 of the byte is broadcast).
	function automatic logic [15:0] ra(input logic [4:0] r, input logic [2:0] g, input logic [7:0] o);
		ra = {r, g, o};
	endfunction

	// Write and read shorthands through the controller model.
	task automatic wr1(input logic [15:0] a, input logic [15:0] d);
		i_rcp_ctrl_model.wr(a, d);
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [15:0] e);
		logic [15:0] v;
		i_rcp_ctrl_model.rd(a, v);
		`chk_eq(v, e)
	endtask

	// Counts, verdict and end of run.
	task automatic complete_run();
		$display("checks=%0d errors=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Cuts a hang short well beyond the expected run of some hundred cycles.
	initial
	begin
		repeat (5000) @(posedge clk_in);
		err_total++;
		complete_run();
	end

	// ------------------------------------------------------------------
	// Test sequence
	// ------------------------------------------------------------------
	// Reset, then memory, region registers, events, pixel control and global register.
	initial
	begin
		repeat (2) @(posedge clk_in);
		@(negedge clk_in);
		resetn_in = 1'b1;
		repeat (3) @(negedge clk_in);
		`chk_eq(col_sel, {1024{1'b1}})
		`chk_eq(mask_row, {512{1'b1}})
		`chk_eq(pulse_row, 512'h0)
		`chk_eq(dcol, 512'h0)
		config_mode_in = 1'b1;
		i_rcp_ctrl_model.wr_word(ra(5'h03, RCP_GRP_LOW, 8'h05), 24'h5AA5C3);
		rd_chk(ra(5'h03, RCP_GRP_LOW, 8'h05), 16'hA5C3);
		rd_chk(ra(5'h03, RCP_GRP_HIGH, 8'h05), 16'h005A);
		wr1(ra(5'h03, RCP_GRP_LOW, 8'h05), 16'h1111);
		rd_chk(ra(5'h03, RCP_GRP_LOW, 8'h05), 16'hA5C3);
		wr1(ra(5'h03, RCP_GRP_HIGH, 8'h06), 16'hFF77);
		rd_chk(ra(5'h03, RCP_GRP_LOW, 8'h06), 16'h1111);
		rd_chk(ra(5'h03, RCP_GRP_HIGH, 8'h06), 16'h0077);
		i_rcp_ctrl_model.wr_word(ra(5'h03, RCP_GRP_LOW, 8'h7B), 24'h123456);
		rd_chk(ra(5'h03, RCP_GRP_HIGH, 8'h7B), 16'h0012);
		rd_chk(ra(5'h03, RCP_GRP_LOW, 8'h7C), 16'h0000);
		i_rcp_ctrl_model.wr_word(ra(5'h00, RCP_GRP_LOW, 8'h80), 24'hABCDEF);
		rd_chk(ra(5'h1F, RCP_GRP_LOW, 8'h00), 16'hCDEF);
		config_mode_in = 1'b0;
		i_rcp_ctrl_model.wr_word(ra(5'h03, RCP_GRP_LOW, 8'h05), 24'h000000);
		rd_chk(ra(5'h03, RCP_GRP_LOW, 8'h05), 16'h0000);
		config_mode_in = 1'b1;
		rd_chk(ra(5'h03, RCP_GRP_LOW, 8'h05), 16'hA5C3);
		wr1(ra(5'h02, RCP_GRP_REGS, 8'h00), 16'hFFFF);
		`chk_eq(dcol[32+:16], 16'hFFFF)
		rd_chk(ra(5'h02, RCP_GRP_REGS, 8'h01), 16'h0004);
		wr1(ra(5'h02, RCP_GRP_REGS, 8'h01), 16'h0000);
		rd_chk(ra(5'h02, RCP_GRP_REGS, 8'h01), 16'h0004);
		wr1(ra(5'h02, RCP_GRP_REGS, 8'h00), 16'hFFFE);
		rd_chk(ra(5'h02, RCP_GRP_REGS, 8'h01), 16'h0000);
		// A stuck pixel in region 4, encoder 9, then a self-test failure there.
		fault_pixel_in = 1'b1;
		fault_region_in = 5'h04;
		fault_dcol_in = 4'h9;
		@(negedge clk_in);
		fault_pixel_in = 1'b0;
		@(negedge clk_in);
		`chk_eq(dcol[64+:16], 16'h0200)
		rd_chk(ra(5'h04, RCP_GRP_REGS, 8'h01), 16'h0001);
		wr1(ra(5'h04, RCP_GRP_REGS, 8'h01), 16'h0001);
		rd_chk(ra(5'h04, RCP_GRP_REGS, 8'h01), 16'h0001);
		mem_fail_in = 1'b1;
		mem_fail_region_in = 5'h04;
		@(negedge clk_in);
		mem_fail_in = 1'b0;
		rd_chk(ra(5'h04, RCP_GRP_REGS, 8'h01), 16'h0003);
		wr1(ra(5'h04, RCP_GRP_REGS, 8'h01), 16'h0000);
		rd_chk(ra(5'h04, RCP_GRP_REGS, 8'h01), 16'h0000);
		wr1(ra(5'h01, RCP_GRP_PIX, 8'h03), 16'hABCD);
		`chk_eq(col_sel[32+:32], 32'hABCDABCD)
		rd_chk(ra(5'h01, RCP_GRP_PIX, 8'h02), 16'hABCD);
		wr1(ra(5'h01, RCP_GRP_PIX, 8'h1F), 16'h1234);
		`chk_eq(col_sel[32+:32], 32'h54325432)
		`chk_eq(mask_row[16+:16], 16'h0000)
		rd_chk(ra(5'h01, RCP_GRP_PIX, 8'h08), 16'hFFFF);
		wr1(ra(5'h00, RCP_GRP_PIX, 8'h84), 16'h00F0);
		`chk_eq(mask_row[496+:16], 16'h00F0)
		wr1(ra(5'h00, RCP_GRP_PIX, 8'h04), 16'h1357);
		`chk_eq(mask_row[31:0], 32'h00F01357)
		wr1(RCP_PIXCFG_ADDR, 16'h0003);
		repeat (3) @(negedge clk_in);
		`chk_eq(pulse_row[31:0], 32'h00F01357)
		`chk_eq(mask_row, 512'h0)
		`chk_eq(pcv, 1'b1)
		rd_chk(RCP_PIXCFG_ADDR, 16'h0003);
		wr1(ra(5'h02, RCP_GRP_PIX, 8'h08), 16'h00A5);
		global_pulse_in = 1'b1;
		@(negedge clk_in);
		`chk_eq(pulse_col[32+:16], 16'h00A5)
		global_pulse_in = 1'b0;
		@(negedge clk_in);
		`chk_eq(pulse_col[32+:16], 16'h0000)
		complete_run();
	end
endmodule
